//--- verilog/frt_channel.sv
// one channel of the 16-bit free-running timer with compare and capture.
// assumes an 8-bit CPU bus on the documented byte offsets, one access per
// cycle, and single-cycle clear strobes from the transfer controller.
`timescale 1ns/1ns
module frt_channel
	import frt_pkg::*;
(
	input  wire logic       CLOCK,
	input  wire logic       SYS_RST,
	input  wire logic [3:0] BUS_ADDR,
	input  wire logic       BUS_WR,
	input  wire logic       BUS_RD,
	input  wire logic [7:0] BUS_WDATA,
	output      logic [7:0] BUS_RDATA,
	input  wire logic       XFER_CLR_CAPTURE,
	input  wire logic       XFER_CLR_MATCH_A,
	input  wire logic       XFER_CLR_MATCH_B,
	input  wire logic       CAPTURE_PIN,
	input  wire logic       EXT_CLOCK,
	output      logic       COMPARE_PIN_A,
	output      logic       COMPARE_PIN_B,
	output      logic       CAPTURE_IRQ,
	output      logic       MATCH_A_IRQ,
	output      logic       MATCH_B_IRQ,
	output      logic       WRAP_IRQ
);

	timer_state_t st_q;
	timer_state_t st_d;
	bus_req_t     req;
	logic         tick;
	logic         cap_edge;
	logic         wr_count_lo;
	logic         wr_cmp_a_lo;
	logic         wr_cmp_b_lo;
	logic         rd_count_hi;
	logic         rd_cap_hi;
	logic         match_a;
	logic         match_b;
	logic         clear_a;
	logic         wrap;
	logic         cap_now;
	logic [3:0]   set_ev;
	logic [3:0]   clr_ev;

	assign req = '{wr: BUS_WR, rd: BUS_RD, addr: BUS_ADDR, data: BUS_WDATA};

	// ==========================================================
	// tick and capture edge source
	frt_tick_source u_tick (
		.clk       (CLOCK),
		.rst       (SYS_RST),
		.clk_sel   (clock_select_t'(st_q.ctrl[1:0])),
		.edge_rise (st_q.mode[MODE_EDGE_SEL]),
		.ext_clk   (EXT_CLOCK),
		.cap_pin   (CAPTURE_PIN),
		.tick      (tick),
		.cap_edge  (cap_edge)
	);

	// ==========================================================
	// access decode
	assign wr_count_lo = req.wr && (req.addr == OFS_COUNT_LO);
	assign wr_cmp_a_lo = req.wr && (req.addr == OFS_CMP_A_LO);
	assign wr_cmp_b_lo = req.wr && (req.addr == OFS_CMP_B_LO);
	assign rd_count_hi = req.rd && (req.addr == OFS_COUNT_HI);
	assign rd_cap_hi   = req.rd && (req.addr == OFS_CAPTURE_HI);

	// ==========================================================
	// events: match taken on the tick that leaves equality
	assign match_a = tick && (st_q.count == st_q.cmp_a) && !wr_cmp_a_lo;
	assign match_b = tick && (st_q.count == st_q.cmp_b) && !wr_cmp_b_lo;
	assign clear_a = match_a && st_q.mode[MODE_CLEAR_A];
	assign wrap    = tick && (st_q.count == COUNT_TOP) && !clear_a && !wr_count_lo;
	assign cap_now = st_q.cap_pend || (cap_edge && !rd_cap_hi);

	// hardware set events per flag; controller clear strobes for capture and both matches, none for wrap
	assign set_ev = {cap_now, match_b, match_a, wrap};
	assign clr_ev = {XFER_CLR_CAPTURE, XFER_CLR_MATCH_B, XFER_CLR_MATCH_A, 1'b0};

	// ==========================================================
	// next state
	always_comb begin
		st_d = st_q;

		// counter: clear beats write, write beats increment
		if (clear_a) begin
			st_d.count = COUNT_RESET;
		end else if (wr_count_lo) begin
			st_d.count = {st_q.temp, req.data};
		end else if (tick) begin
			st_d.count = st_q.count + 16'h0001;
		end

		// compare pins follow level bits only while enabled
		if (match_a && st_q.ctrl[CTRL_ENABLE_A]) begin
			st_d.pin_a = st_q.mode[MODE_LEVEL_A];
		end
		if (match_b && st_q.ctrl[CTRL_ENABLE_B]) begin
			st_d.pin_b = st_q.mode[MODE_LEVEL_B];
		end

		// capture, possibly held one cycle behind an upper-byte read
		st_d.cap_pend = cap_edge && rd_cap_hi;
		if (cap_now) begin
			st_d.cap = st_q.count;
		end

		// flag clears: armed zero write or controller strobe
		for (int i = 0; i < 4; i++) begin
			if (req.wr && (req.addr == OFS_STATUS) && !req.data[FLAG_LSB + i] && st_q.armed[i]) begin
				st_d.flags[i] = 1'b0;
				st_d.armed[i] = 1'b0;
			end
			if (clr_ev[i]) begin
				st_d.flags[i] = 1'b0;
				st_d.armed[i] = 1'b0;
			end
			// a set in the same cycle as a clear wins
			if (set_ev[i]) begin
				st_d.flags[i] = 1'b1;
			end
		end

		// reading status while a flag is set arms its clear
		if (req.rd && (req.addr == OFS_STATUS)) begin
			st_d.armed = st_q.armed | st_q.flags;
		end

		// register writes; ones into flag bits are ignored
		if (req.wr) begin
			unique case (req.addr)
				OFS_TIMER_CONTROL: st_d.ctrl = req.data;
				OFS_STATUS:        st_d.mode = req.data[3:0];
				OFS_COUNT_HI, OFS_CMP_A_HI, OFS_CMP_B_HI, OFS_CAPTURE_HI: st_d.temp = req.data;
				OFS_CMP_A_LO:      st_d.cmp_a = {st_q.temp, req.data};
				OFS_CMP_B_LO:      st_d.cmp_b = {st_q.temp, req.data};
				default:           st_d.temp = st_q.temp;
			endcase
		end

		// read data, registered one cycle after the strobe
		if (req.rd) begin
			unique case (req.addr)
				OFS_TIMER_CONTROL: st_d.rd_data = st_q.ctrl;
				OFS_STATUS:        st_d.rd_data = {st_q.flags, st_q.mode};
				OFS_COUNT_HI:      st_d.rd_data = st_q.count[15:8];
				OFS_COUNT_LO:      st_d.rd_data = st_q.temp;
				OFS_CMP_A_HI:      st_d.rd_data = st_q.cmp_a[15:8];
				OFS_CMP_A_LO:      st_d.rd_data = st_q.cmp_a[7:0];
				OFS_CMP_B_HI:      st_d.rd_data = st_q.cmp_b[15:8];
				OFS_CMP_B_LO:      st_d.rd_data = st_q.cmp_b[7:0];
				OFS_CAPTURE_HI:    st_d.rd_data = st_q.cap[15:8];
				OFS_CAPTURE_LO:    st_d.rd_data = st_q.temp;
				default:           st_d.rd_data = UNMAPPED_READ;
			endcase
			// count and capture upper reads save the concurrent lower byte
			if (rd_count_hi) begin
				st_d.temp = st_q.count[7:0];
			end
			if (rd_cap_hi) begin
				st_d.temp = st_q.cap[7:0];
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			st_q.count    <= COUNT_RESET;
			st_q.cmp_a    <= CMP_RESET;
			st_q.cmp_b    <= CMP_RESET;
			st_q.cap      <= CAPTURE_RESET;
			st_q.ctrl     <= BYTE_RESET;
			st_q.flags    <= 4'h0;
			st_q.armed    <= 4'h0;
			st_q.mode     <= 4'h0;
			st_q.temp     <= BYTE_RESET;
			st_q.rd_data  <= BYTE_RESET;
			st_q.pin_a    <= 1'b0;
			st_q.pin_b    <= 1'b0;
			st_q.cap_pend <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// outputs
	assign BUS_RDATA     = st_q.rd_data;
	assign COMPARE_PIN_A = st_q.pin_a;
	assign COMPARE_PIN_B = st_q.pin_b;

	// each request is its flag gated by its enable
	assign CAPTURE_IRQ = st_q.flags[FLAG_CAPTURE] & st_q.ctrl[CTRL_IE_LSB + FLAG_CAPTURE];
	assign MATCH_B_IRQ = st_q.flags[FLAG_MATCH_B] & st_q.ctrl[CTRL_IE_LSB + FLAG_MATCH_B];
	assign MATCH_A_IRQ = st_q.flags[FLAG_MATCH_A] & st_q.ctrl[CTRL_IE_LSB + FLAG_MATCH_A];
	assign WRAP_IRQ    = st_q.flags[FLAG_WRAP] & st_q.ctrl[CTRL_IE_LSB + FLAG_WRAP];

	// ==========================================================
	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	sequence hi_read_s;
		rd_count_hi && !BUS_WR;
	endsequence
	sequence lo_read_s;
		BUS_RD && (BUS_ADDR == OFS_COUNT_LO);
	endsequence
	sequence delayed_edge_s;
		cap_edge && rd_cap_hi ##1 st_q.cap_pend;
	endsequence

	capture_load_a: assert property (cap_now |=> st_q.flags[FLAG_CAPTURE] && st_q.cap == $past(st_q.count))
		else $error("capture did not load count or set flag");
	capture_delay_a: assert property (delayed_edge_s |=> st_q.cap == $past(st_q.count))
		else $error("delayed capture not taken one cycle later");
	match_b_flag_a: assert property (tick && st_q.count == st_q.cmp_b && !wr_cmp_b_lo |=> st_q.flags[FLAG_MATCH_B])
		else $error("match B flag not set");
	pin_a_level_a: assert property (match_a && st_q.ctrl[CTRL_ENABLE_A] |=> COMPARE_PIN_A == $past(st_q.mode[MODE_LEVEL_A]))
		else $error("pin A not driven to level");
	pin_b_hold_a: assert property (!st_q.ctrl[CTRL_ENABLE_B] |=> $stable(COMPARE_PIN_B))
		else $error("pin B changed while disabled");
	clear_on_a_a: assert property (match_a && st_q.mode[MODE_CLEAR_A] |=> st_q.count == COUNT_RESET)
		else $error("counter not cleared at match A");
	wrap_flag_a: assert property (tick && st_q.count == COUNT_TOP && !clear_a && !wr_count_lo |=> st_q.flags[FLAG_WRAP] && st_q.count == COUNT_RESET)
		else $error("wrap flag not set on wrap");
	flag_no_set_a: assert property (!st_q.flags[FLAG_WRAP] && !wrap |=> !st_q.flags[FLAG_WRAP])
		else $error("wrap flag set without wrap");
	unarmed_clear_a: assert property (st_q.flags[FLAG_MATCH_A] && !st_q.armed[FLAG_MATCH_A] && !XFER_CLR_MATCH_A |=> st_q.flags[FLAG_MATCH_A])
		else $error("unarmed flag cleared");
	count_commit_a: assert property (wr_count_lo && !clear_a |=> st_q.count == {$past(st_q.temp), $past(BUS_WDATA)})
		else $error("counter word not committed");
	split_read_a: assert property (hi_read_s ##1 lo_read_s |=> BUS_RDATA == $past(st_q.count[7:0], 2))
		else $error("lower byte not taken from latch");
	count_step_a: assert property (tick && !clear_a && !wr_count_lo |=> st_q.count == $past(st_q.count) + 16'h0001)
		else $error("counter did not step on tick");

endmodule

//--- verilog/frt_pkg.sv
// package for the free-running timer channel: register map, field layout,
// reset values, clock select codes and the carriers shared by the modules.
// assumes an 8-bit CPU bus with byte offsets relative to the channel base.
package frt_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [3:0] OFS_TIMER_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STATUS        = 4'h1;
	localparam logic [3:0] OFS_COUNT_HI      = 4'h2;
	localparam logic [3:0] OFS_COUNT_LO      = 4'h3;
	localparam logic [3:0] OFS_CMP_A_HI      = 4'h4;
	localparam logic [3:0] OFS_CMP_A_LO      = 4'h5;
	localparam logic [3:0] OFS_CMP_B_HI      = 4'h6;
	localparam logic [3:0] OFS_CMP_B_LO      = 4'h7;
	localparam logic [3:0] OFS_CAPTURE_HI    = 4'h8;
	localparam logic [3:0] OFS_CAPTURE_LO    = 4'h9;

	// ==========================================================
	// reset values, counter top and unmapped read value
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] CMP_RESET     = 16'hFFFF;
	localparam logic [15:0] CAPTURE_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TOP     = 16'hFFFF;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;

	// ==========================================================
	// flag index inside the four-bit flag field (status bits 7..4)
	localparam int FLAG_WRAP    = 0;
	localparam int FLAG_MATCH_A = 1;
	localparam int FLAG_MATCH_B = 2;
	localparam int FLAG_CAPTURE = 3;
	localparam int FLAG_LSB     = 4;

	// status low nibble and timer control bit positions
	localparam int MODE_CLEAR_A  = 0;
	localparam int MODE_EDGE_SEL = 1;
	localparam int MODE_LEVEL_A  = 2;
	localparam int MODE_LEVEL_B  = 3;
	localparam int CTRL_ENABLE_A = 2;
	localparam int CTRL_ENABLE_B = 3;
	localparam int CTRL_IE_LSB   = 4;

	// ==========================================================
	// clock select codes and prescaler masks
	typedef enum logic [1:0] {
		CLK_DIV4  = 2'b00,
		CLK_DIV8  = 2'b01,
		CLK_DIV32 = 2'b10,
		CLK_EXT   = 2'b11
	} clock_select_t;
	localparam logic [4:0] DIV4_MASK  = 5'h03;
	localparam logic [4:0] DIV8_MASK  = 5'h07;
	localparam logic [4:0] DIV32_MASK = 5'h1F;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] data;
	} bus_req_t;

	typedef struct packed {
		logic [4:0] prescale;
		logic       ext_prev;
		logic       cap_prev;
	} tick_state_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] cap;
		logic [7:0]  ctrl;
		logic [3:0]  flags;
		logic [3:0]  armed;
		logic [3:0]  mode;
		logic [7:0]  temp;
		logic [7:0]  rd_data;
		logic        pin_a;
		logic        pin_b;
		logic        cap_pend;
	} timer_state_t;

endpackage

//--- verilog/frt_tick_source.sv
// count tick generator and capture edge detector of the timer channel.
// assumes the external clock and capture pin are synchronous to CLOCK.
`timescale 1ns/1ns
module frt_tick_source
	import frt_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire clock_select_t clk_sel,
	input  wire logic          edge_rise,
	input  wire logic          ext_clk,
	input  wire logic          cap_pin,
	output      logic          tick,
	output      logic          cap_edge
);

	tick_state_t st_q;
	tick_state_t st_d;

	// ==========================================================
	// prescaler and edge detection
	always_comb begin
		st_d          = st_q;
		st_d.prescale = st_q.prescale + 5'h01;
		st_d.ext_prev = ext_clk;
		st_d.cap_prev = cap_pin;
		unique case (clk_sel)
			CLK_DIV4:  tick = ((st_q.prescale & DIV4_MASK) == DIV4_MASK);
			CLK_DIV8:  tick = ((st_q.prescale & DIV8_MASK) == DIV8_MASK);
			CLK_DIV32: tick = ((st_q.prescale & DIV32_MASK) == DIV32_MASK);
			CLK_EXT:   tick = ext_clk & ~st_q.ext_prev;
		endcase
		// falling edge when select is 0, rising when 1
		cap_edge = edge_rise ? (cap_pin & ~st_q.cap_prev) : (~cap_pin & st_q.cap_prev);
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

//--- tb/cpu_bus_model.sv
// CPU and transfer controller model on the timer channel's byte bus.
// assumes the bench clock; every request changes at the falling edge.
`timescale 1ns/1ns
module cpu_bus_model
	import frt_pkg::*;
(
	input  wire logic       clk,
	output      logic [3:0] addr,
	output      logic       wr,
	output      logic       rd,
	output      logic [7:0] wdata,
	input  wire logic [7:0] rdata,
	output      logic [2:0] clr
);
	// ==========================================
	// idle bus
	initial begin
		addr = 4'hF;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'hA5;
		clr = 3'h0;
	end

	// ==========================================
	// byte and word cycles
	// single byte write; released data is scrambled
	task automatic w8(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		wdata = ~d;
	endtask

	// word write, upper byte first
	task automatic w16(input logic [3:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wdata = d[15:8];
		wr = 1'b1;
		@(negedge clk);
		addr = a + 4'h1;
		wdata = d[7:0];
		@(negedge clk);
		wr = 1'b0;
		wdata = ~d[7:0];
	endtask

	// single byte read, data taken the cycle after the strobe
	task automatic r8(input logic [3:0] a, output logic [15:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = {8'h00, rdata};
	endtask

	// word read, upper byte first
	task automatic r16(input logic [3:0] a, output logic [15:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		addr = a + 4'h1;
		d[15:8] = rdata;
		@(negedge clk);
		rd = 1'b0;
		d[7:0] = rdata;
	endtask

	// one-cycle service pulse of the transfer controller
	task automatic xfer(input logic [2:0] m);
		@(negedge clk);
		clr = m;
		@(negedge clk);
		clr = 3'h0;
	endtask
endmodule

//--- tb/test_free_running_timer_channel.sv
// self-checking bench for the free-running timer channel.
// assumes the cpu_bus_model partner and the frt_pkg constants.
`timescale 1ns/1ns
module test_free_running_timer_channel
	import frt_pkg::*;
;
	logic            CLOCK;
	logic            SYS_RST;
	logic            CAPTURE_PIN;
	logic            EXT_CLOCK;
	wire logic [3:0] BUS_ADDR;
	wire logic       BUS_WR;
	wire logic       BUS_RD;
	wire logic [7:0] BUS_WDATA;
	wire logic [7:0] BUS_RDATA;
	wire logic [2:0] clr;
	wire logic [1:0] pins;
	wire logic [3:0] irq;
	logic [15:0]     w;
	int              bad_count = 0;
	int              checked = 0;
	int              cycles = 0;

	frt_channel frt_channel_inst (
		.CLOCK(CLOCK),
		.SYS_RST(SYS_RST),
		.BUS_ADDR(BUS_ADDR),
		.BUS_WR(BUS_WR),
		.BUS_RD(BUS_RD),
		.BUS_WDATA(BUS_WDATA),
		.BUS_RDATA(BUS_RDATA),
		.XFER_CLR_CAPTURE(clr[0]),
		.XFER_CLR_MATCH_A(clr[1]),
		.XFER_CLR_MATCH_B(clr[2]),
		.CAPTURE_PIN(CAPTURE_PIN),
		.EXT_CLOCK(EXT_CLOCK),
		.COMPARE_PIN_A(pins[0]),
		.COMPARE_PIN_B(pins[1]),
		.CAPTURE_IRQ(irq[3]),
		.MATCH_A_IRQ(irq[1]),
		.MATCH_B_IRQ(irq[2]),
		.WRAP_IRQ(irq[0])
	);

	cpu_bus_model cpu (
		.clk(CLOCK),
		.addr(BUS_ADDR),
		.wr(BUS_WR),
		.rd(BUS_RD),
		.wdata(BUS_WDATA),
		.rdata(BUS_RDATA),
		.clr(clr)
	);

	// ==========================================
	// clock, hang guard and reporting
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	// hang guard, well above the expected run
	always @(posedge CLOCK) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			bad_count++;
			results();
		end
	end

	task automatic results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one external count clock period
	task automatic pulse();
		@(negedge CLOCK);
		EXT_CLOCK = 1'b1;
		repeat (2) @(negedge CLOCK);
		EXT_CLOCK = 1'b0;
		repeat (3) @(negedge CLOCK);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		cpu.r8(OFS_TIMER_CONTROL, w);
		chk(w, 16'h0000);
		cpu.r8(OFS_STATUS, w);
		chk(w, 16'h0000);
		cpu.r16(OFS_CMP_A_HI, w);
		chk(w, CMP_RESET);
		cpu.r16(OFS_CAPTURE_HI, w);
		chk(w, CAPTURE_RESET);
		cpu.r8(4'hA, w);
		chk(w, {8'h00, UNMAPPED_READ});
	endtask

	task automatic t_latch();
		cpu.w8(OFS_TIMER_CONTROL, 8'h03);
		cpu.w16(OFS_COUNT_HI, 16'h12FE);
		cpu.r16(OFS_COUNT_HI, w);
		chk(w, 16'h12FE);
		pulse();
		pulse();
		cpu.r16(OFS_COUNT_HI, w);
		chk(w, 16'h1300);
		cpu.w16(OFS_CMP_B_HI, 16'hABCD);
		cpu.r8(OFS_CMP_B_LO, w);
		chk(w, 16'h00CD);
		cpu.w8(OFS_CMP_B_HI, 8'h55);
		cpu.r16(OFS_CMP_B_HI, w);
		chk(w, 16'hABCD);
		cpu.w8(OFS_CMP_B_LO, 8'h66);
		cpu.r16(OFS_CMP_B_HI, w);
		chk(w, 16'h5566);
	endtask

	task automatic t_match_a();
		cpu.w8(OFS_TIMER_CONTROL, 8'h27);
		cpu.w16(OFS_CMP_A_HI, 16'h0005);
		cpu.w8(OFS_STATUS, 8'h05);
		cpu.w16(OFS_COUNT_HI, 16'h0004);
		pulse();
		cpu.r8(OFS_STATUS, w);
		chk(w, 16'h0005);
		pulse();
		chk({14'h0, pins}, 16'h0001);
		chk({12'h0, irq}, 16'h0002);
		cpu.r16(OFS_COUNT_HI, w);
		chk(w, 16'h0000);
		cpu.w8(OFS_STATUS, 8'h05);
		cpu.r8(OFS_STATUS, w);
		chk(w, 16'h0025);
		cpu.w8(OFS_STATUS, 8'hF5);
		cpu.r8(OFS_STATUS, w);
		chk(w, 16'h0025);
		cpu.w8(OFS_STATUS, 8'h05);
		cpu.r8(OFS_STATUS, w);
		chk(w, 16'h0005);
	endtask

	task automatic t_match_b();
		cpu.w8(OFS_TIMER_CONTROL, 8'h43);
		cpu.w16(OFS_CMP_B_HI, 16'h0001);
		cpu.w8(OFS_STATUS, 8'h08);
		pulse();
		pulse();
		chk({14'h0, pins}, 16'h0001);
		chk({12'h0, irq}, 16'h0004);
		cpu.xfer(3'b100);
		chk({12'h0, irq}, 16'h0000);
		cpu.w8(OFS_TIMER_CONTROL, 8'h4B);
		cpu.w16(OFS_COUNT_HI, 16'h0001);
		pulse();
		chk({14'h0, pins}, 16'h0003);
	endtask

	task automatic t_wrap();
		cpu.w8(OFS_TIMER_CONTROL, 8'h13);
		cpu.w16(OFS_COUNT_HI, 16'hFFFF);
		pulse();
		chk({12'h0, irq}, 16'h0001);
		cpu.r8(OFS_STATUS, w);
		chk(w, 16'h0058);
		cpu.w8(OFS_STATUS, 8'h08);
		chk({12'h0, irq}, 16'h0000);
	endtask

	task automatic t_capture();
		cpu.w8(OFS_TIMER_CONTROL, 8'h83);
		cpu.w8(OFS_STATUS, 8'h00);
		cpu.w16(OFS_COUNT_HI, 16'h0077);
		@(negedge CLOCK);
		CAPTURE_PIN = 1'b0;
		repeat (4) @(negedge CLOCK);
		chk({12'h0, irq}, 16'h0008);
		cpu.r16(OFS_CAPTURE_HI, w);
		chk(w, 16'h0077);
		cpu.xfer(3'b001);
		chk({12'h0, irq}, 16'h0000);
		cpu.w8(OFS_STATUS, 8'h02);
		cpu.w16(OFS_COUNT_HI, 16'h0123);
		@(negedge CLOCK);
		CAPTURE_PIN = 1'b1;
		repeat (4) @(negedge CLOCK);
		chk({12'h0, irq}, 16'h0008);
		cpu.r16(OFS_CAPTURE_HI, w);
		chk(w, 16'h0123);
	endtask

	// counter advance over 96 cycles for each internal divider
	task automatic t_prescale();
		int          sh[3] = '{2, 3, 5};
		logic [15:0] e;
		for (int i = 0; i < 3; i++) begin
			cpu.w8(OFS_TIMER_CONTROL, 8'(i));
			cpu.w16(OFS_COUNT_HI, 16'h0000);
			repeat (96) @(negedge CLOCK);
			cpu.r16(OFS_COUNT_HI, w);
			e = 16'(96 >> sh[i]);
			chk({15'h0, (w + 16'h1 >= e) && (w <= e + 16'h1)}, 16'h0001);
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		SYS_RST = 1'b1;
		CAPTURE_PIN = 1'b1;
		EXT_CLOCK = 1'b0;
		repeat (20) @(negedge CLOCK);
		SYS_RST = 1'b0;
		t_reset();
		t_latch();
		t_match_a();
		t_match_b();
		t_wrap();
		t_capture();
		t_prescale();
		results();
	end
endmodule
